// File: lmu_i2c_map.svh
// lmu_i2c_map.svh: offsets, field positions, reset values and timing
// figures shared by both ends of the register link.
// assumes it is included by its bare name before any use.
`ifndef LMU_I2C_MAP_SVH
`define LMU_I2C_MAP_SVH

// ============================================================
// link addressing
`define SLAVE_ADDR        7'h59
`define RW_WRITE          1'b0
`define RW_READ           1'b1

// ============================================================
// register indexes and layout
`define REG_IO_CTRL       8'h06
`define REG_IO_DATA       8'h07
`define CTRL_PWM_BIT      4
`define CTRL_WMASK        8'h17
`define DATA_WMASK        8'h07
`define CTRL_RESET        8'h00
`define DATA_RESET        8'h00
`define IO_PINS           3

// ============================================================
// timing
`define I2C_SCL_PERIOD_NS 2500
`define CORE_CLK_PERIOD_NS 8

`endif

// File: lmu_i2c_pkg.sv
// lmu_i2c_pkg.sv: state and symbol types of both link ends.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lmu_i2c_pkg;
  // device link states
  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_RX,
    DEV_ACK,
    DEV_TX,
    DEV_TXACK
  } dev_state_t;

  // host engine states
  typedef enum logic {
    HOST_IDLE,
    HOST_RUN
  } host_state_t;

  // bus symbols the host sequences through
  typedef enum logic [1:0] {
    SYM_START,
    SYM_BYTE_TX,
    SYM_BYTE_RX,
    SYM_STOP
  } sym_t;
endpackage : lmu_i2c_pkg

`default_nettype wire

// File: lmu_i2c_link_if.sv
// lmu_i2c_link_if.sv: the two-wire link between host and device.
// assumes pull-ups on both lines; wired-and resolution is done here.
`default_nettype none

interface lmu_i2c_link_if;
  logic hostSclOut;  // host clock level when driving
  logic hostSclOe;   // host drives clock line
  logic hostSdaOut;  // host data level when driving
  logic hostSdaOe;   // host drives data line
  logic devSdaOut;   // device data level when driving
  logic devSdaOe;    // device drives data line
  logic scl;         // resolved clock line
  logic sda;         // resolved data line

  // open drain: any low driver wins, otherwise pull-up
  assign scl = (hostSclOe & ~hostSclOut) ? 1'b0 : 1'b1;
  assign sda = ((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut))
             ? 1'b0 : 1'b1;

  modport host (output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe,
                input scl, sda);
  modport device (output devSdaOut, devSdaOe, input scl, sda);
endinterface : lmu_i2c_link_if

`default_nettype wire

// File: lmu_i2c_device.sv
// lmu_i2c_device.sv: register slave of the lighting unit with its
// three-pin general purpose port, all on the link clock.
// assumes linkClk oversamples scl well above 400 kHz and rst_n is
// synchronous to linkClk.
`include "lmu_i2c_map.svh"
`default_nettype none

module lmu_i2c_device (
  input  wire logic              linkClk,  // link oversampling clock
  input  wire logic              rst_n,    // sync reset, active low
  lmu_i2c_link_if.device         link,     // two-wire link
  input  wire logic [`IO_PINS-1:0] gpioIn,  // pin input levels
  output logic      [`IO_PINS-1:0] gpioOut, // pin output levels
  output logic      [`IO_PINS-1:0] gpioOe,  // pin output enables
  output logic                   pwmEnable, // pin 0 is PWM input
  output logic                   pwmInput   // sampled pin 0 level
);

  // ============================================================
  // line synchronisers
  logic [2:0]          sclSync;    // [0] meta, [1] clean, [2] prev
  logic [2:0]          sdaSync;    // [0] meta, [1] clean, [2] prev
  logic [`IO_PINS-1:0] pinMeta;    // first pin stage
  logic [`IO_PINS-1:0] pinLevel;   // clean pin levels

  // lines and pins cross from other clocks: two flops before any use;
  // no reset needed, the state machine ignores them until released
  always_ff @(posedge linkClk)
  begin
    sclSync  <= {sclSync[1:0], link.scl};
    sdaSync  <= {sdaSync[1:0], link.sda};
    pinMeta  <= gpioIn;
    pinLevel <= pinMeta;
  end

  logic sclNow;    // clean clock
  logic sclPrev;   // clock one cycle ago
  logic sdaNow;    // clean data
  logic sdaPrev;   // data one cycle ago
  logic sclRise;   // clock rising edge
  logic sclFall;   // clock falling edge
  logic startSeen; // start or repeated start
  logic stopSeen;  // stop
  assign sclNow  = sclSync[1];
  assign sclPrev = sclSync[2];
  assign sdaNow  = sdaSync[1];
  assign sdaPrev = sdaSync[2];
  assign sclRise = sclNow & ~sclPrev;
  assign sclFall = ~sclNow & sclPrev;
  // data moving under a steady high clock is a frame mark
  assign startSeen = sclNow & sclPrev & sdaPrev & ~sdaNow;
  assign stopSeen  = sclNow & sclPrev & ~sdaPrev & sdaNow;

  // ============================================================
  // registers
  logic [7:0] ctrlReg;     // direction bits and PWM select
  logic [7:0] dataReg;     // output data bits
  logic [7:0] shiftIn;     // received byte
  logic [7:0] regIndex;    // selected register
  logic [7:0] readValue;   // byte returned on a read
  logic       commitWrite; // data byte acknowledged
  logic       readMode;    // current access is a read

  lmu_i2c_pkg::dev_state_t state; // link state
  logic [3:0] bitCnt;             // bits of current byte
  logic [1:0] byteCnt;            // 0 addr, 1 index, 2 data
  logic [7:0] shiftOut;           // byte being sent
  logic       sdaLow;             // pull data line low
  logic       masterAck;          // master acked last byte

  // the write takes effect on the rise of the device's ack clock
  assign commitWrite = (state == lmu_i2c_pkg::DEV_ACK) && sclRise
                     && (byteCnt == 2'h2) && !readMode;

  // unknown indexes read as zero
  always_comb
  begin
    unique case (regIndex)
      `REG_IO_CTRL: readValue = ctrlReg;
      `REG_IO_DATA: readValue = {5'h00, pinLevel};
      default:      readValue = 8'h00;
    endcase
  end

  // register writes, masked to implemented bits
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      ctrlReg <= `CTRL_RESET;
      dataReg <= `DATA_RESET;
    end
    else if (commitWrite)
    begin
      unique case (regIndex)
        `REG_IO_CTRL: ctrlReg <= shiftIn & `CTRL_WMASK;
        `REG_IO_DATA: dataReg <= shiftIn & `DATA_WMASK;
        default:      ;
      endcase
    end
  end

  // index latched on the index byte's ack clock
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
      regIndex <= 8'h00;
    else if (state == lmu_i2c_pkg::DEV_ACK && sclRise && byteCnt == 2'h1)
      regIndex <= shiftIn;
  end

  // ============================================================
  // link state machine
  // data-line changes follow a seen clock fall: steady while clock high
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      state     <= lmu_i2c_pkg::DEV_IDLE;
      bitCnt    <= 4'h0;
      byteCnt   <= 2'h0;
      sdaLow    <= 1'b0;
      readMode  <= 1'b0;
      masterAck <= 1'b0;
    end
    else if (startSeen)
    begin
      // first and repeated starts behave alike
      state   <= lmu_i2c_pkg::DEV_RX;
      bitCnt  <= 4'h0;
      byteCnt <= 2'h0;
      sdaLow  <= 1'b0;
    end
    else if (stopSeen)
    begin
      state  <= lmu_i2c_pkg::DEV_IDLE;
      sdaLow <= 1'b0;
    end
    else
    begin
      unique case (state)
        lmu_i2c_pkg::DEV_IDLE: ;
        lmu_i2c_pkg::DEV_RX:
        begin
          if (sclRise)
          begin
            shiftIn <= {shiftIn[6:0], sdaNow};
            bitCnt  <= bitCnt + 4'h1;
          end
          else if (sclFall && bitCnt == 4'h8)
          begin
            // foreign address: stay off the line until next start
            if (byteCnt == 2'h0 && shiftIn[7:1] != `SLAVE_ADDR)
              state <= lmu_i2c_pkg::DEV_IDLE;
            else
            begin
              state  <= lmu_i2c_pkg::DEV_ACK;
              sdaLow <= 1'b1;
              if (byteCnt == 2'h0)
                readMode <= (shiftIn[0] == `RW_READ);
            end
          end
        end
        lmu_i2c_pkg::DEV_ACK:
        begin
          if (sclFall)
          begin
            bitCnt <= 4'h0;
            if (readMode)
            begin
              // read returns the register chosen before the restart
              state    <= lmu_i2c_pkg::DEV_TX;
              shiftOut <= readValue;
              sdaLow   <= ~readValue[7];
            end
            else
            begin
              state  <= lmu_i2c_pkg::DEV_RX;
              sdaLow <= 1'b0;
              // later data bytes rewrite the same register
              if (byteCnt != 2'h2)
                byteCnt <= byteCnt + 2'h1;
            end
          end
        end
        lmu_i2c_pkg::DEV_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt == 4'h7)
            begin
              state  <= lmu_i2c_pkg::DEV_TXACK;
              sdaLow <= 1'b0;
            end
            else
            begin
              shiftOut <= {shiftOut[6:0], 1'b0};
              sdaLow   <= ~shiftOut[6];
              bitCnt   <= bitCnt + 4'h1;
            end
          end
        end
        lmu_i2c_pkg::DEV_TXACK:
        begin
          if (sclRise)
            masterAck <= ~sdaNow;
          else if (sclFall)
          begin
            bitCnt <= 4'h0;
            // a nack ends the read; the master follows with stop
            if (masterAck)
            begin
              state    <= lmu_i2c_pkg::DEV_TX;
              shiftOut <= readValue;
              sdaLow   <= ~readValue[7];
            end
            else
              state <= lmu_i2c_pkg::DEV_IDLE;
          end
        end
      endcase
    end
  end

  assign link.devSdaOut = 1'b0;   // open drain, only ever pulls low
  assign link.devSdaOe  = sdaLow;

  // ============================================================
  // general purpose pins
  always_ff @(posedge linkClk)
  begin
    if (!rst_n)
    begin
      gpioOut   <= '0;
      pwmEnable <= 1'b0;
      pwmInput  <= 1'b0;
    end
    else
    begin
      gpioOut   <= dataReg[`IO_PINS-1:0];
      pwmEnable <= ctrlReg[`CTRL_PWM_BIT];
      pwmInput  <= pinLevel[0];
    end
  end

  // per pin enable; the PWM override exists on pin 0 alone
  for (genvar i = 0; i < `IO_PINS; i++)
  begin : g_pin
    assign gpioOe[i] = ctrlReg[i]
                     & ~((i == 0) && ctrlReg[`CTRL_PWM_BIT]);
  end

endmodule : lmu_i2c_device

`default_nettype wire

// File: lmu_i2c_host.sv
// lmu_i2c_host.sv: bus master that writes and reads the device's
// registers; makes scl from core_clk and buffers read answers.
// assumes the far end is the lighting unit's register slave.
`include "lmu_i2c_map.svh"
`default_nettype none

module lmu_i2c_host #(
  parameter int SCL_PERIOD_NS = `I2C_SCL_PERIOD_NS // bus clock period
) (
  input  wire logic       core_clk, // system clock
  input  wire logic       rst_n,    // sync reset, active low
  lmu_i2c_link_if.host    link,     // two-wire link
  input  wire logic       cmdValid, // command offered
  output logic            cmdReady, // command taken
  input  wire logic       cmdRead,  // 1 read, 0 write
  input  wire logic [7:0] cmdIndex, // register index
  input  wire logic [7:0] cmdData,  // write data
  output logic            rspValid, // read answer offered
  input  wire logic       rspReady, // read answer taken
  output logic [7:0]      rspData,  // read byte
  output logic            rspError  // device did not ack
);

  // a quarter bus period is a least time, so round up
  localparam int QUARTER_CYCLES = (SCL_PERIOD_NS
    + 4 * `CORE_CLK_PERIOD_NS - 1) / (4 * `CORE_CLK_PERIOD_NS);
  if (QUARTER_CYCLES < 4 || QUARTER_CYCLES > 4096)
  begin : g_check
    $error("SCL_PERIOD_NS out of range");
  end

  // ============================================================
  // engine state
  lmu_i2c_pkg::host_state_t state; // idle or running
  lmu_i2c_pkg::sym_t kind;        // symbol of current step
  logic [12:0] qCnt;               // cycles in quarter
  logic [1:0]  phase;              // quarter of symbol
  logic [2:0]  step;               // symbol index
  logic [3:0]  bitIdx;             // bit within byte, 8 = ack
  logic        isRead;             // current command reads
  logic [7:0]  regIdx;             // latched index
  logic [7:0]  wrData;             // latched data
  logic [7:0]  txByte;             // byte of current step
  logic [7:0]  rxShift;            // byte being read
  logic        nackSeen;           // device refused a byte
  logic        wantScl;            // desired clock level
  logic        wantSda;            // desired data level
  logic        bitVal;             // bit sent this slot
  logic        qTick;              // last cycle of quarter
  logic [1:0]  sdaSync;            // [0] meta, [1] clean
  logic        sclDrvLow;          // pull clock low
  logic        sdaDrvLow;          // pull data low
  logic        pushRsp;            // read finished

  assign qTick = (qCnt == 13'(QUARTER_CYCLES - 1));

  // data line comes from the far end, two flops first
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sdaSync <= 2'h3;
    else
      sdaSync <= {sdaSync[0], link.sda};
  end

  // symbol of each step; read trades the data byte for a restart, a read address byte and a read byte
  always_comb
  begin
    kind   = lmu_i2c_pkg::SYM_STOP;
    txByte = 8'h00;
    unique case (step)
      3'h0: kind = lmu_i2c_pkg::SYM_START;
      3'h1:
      begin
        kind   = lmu_i2c_pkg::SYM_BYTE_TX;
        txByte = {`SLAVE_ADDR, `RW_WRITE};
      end
      3'h2:
      begin
        kind   = lmu_i2c_pkg::SYM_BYTE_TX;
        txByte = regIdx;
      end
      3'h3:
      begin
        kind   = isRead ? lmu_i2c_pkg::SYM_START
                        : lmu_i2c_pkg::SYM_BYTE_TX;
        txByte = wrData;
      end
      3'h4:
      begin
        kind   = isRead ? lmu_i2c_pkg::SYM_BYTE_TX
                        : lmu_i2c_pkg::SYM_STOP;
        txByte = {`SLAVE_ADDR, `RW_READ};
      end
      3'h5: kind = isRead ? lmu_i2c_pkg::SYM_BYTE_RX
                          : lmu_i2c_pkg::SYM_STOP;
      default: kind = lmu_i2c_pkg::SYM_STOP;
    endcase
  end

  // line levels per quarter; data bits move sda in quarter 0, start and stop in quarter 2
  always_comb
  begin
    // ack slot and read bits are released; a read ends with nack
    bitVal = (kind == lmu_i2c_pkg::SYM_BYTE_TX && bitIdx < 4'h8)
           ? txByte[3'(4'h7 - bitIdx)] : 1'b1;
    wantScl = 1'b1;
    wantSda = 1'b1;
    if (state == lmu_i2c_pkg::HOST_RUN)
    begin
      unique case (kind)
        lmu_i2c_pkg::SYM_START:
        begin
          wantScl = (phase == 2'h1) || (phase == 2'h2);
          wantSda = (phase == 2'h0) || (phase == 2'h1);
        end
        lmu_i2c_pkg::SYM_STOP:
        begin
          wantScl = (phase != 2'h0);
          wantSda = (phase == 2'h2) || (phase == 2'h3);
        end
        default:
        begin
          wantScl = (phase == 2'h1) || (phase == 2'h2);
          wantSda = bitVal;
        end
      endcase
    end
  end

  // line drivers from flops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sclDrvLow <= 1'b0;
      sdaDrvLow <= 1'b0;
    end
    else
    begin
      sclDrvLow <= ~wantScl;
      sdaDrvLow <= ~wantSda;
    end
  end

  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe  = sclDrvLow;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = sdaDrvLow;

  // ============================================================
  // answer buffer, two entries
  logic [8:0] bufMem [2];  // {error, byte}
  logic       wrPtr;       // next slot to fill
  logic       rdPtr;       // next slot to drain
  logic [1:0] bufCount;    // entries held

  assign pushRsp = (state == lmu_i2c_pkg::HOST_RUN) && qTick
                 && (phase == 2'h3) && (kind == lmu_i2c_pkg::SYM_STOP)
                 && isRead;
  assign rspValid = (bufCount != 2'h0);
  assign {rspError, rspData} = bufMem[rdPtr];
  // no new read starts without room for its answer
  assign cmdReady = (state == lmu_i2c_pkg::HOST_IDLE)
                  && (bufCount != 2'h2);

  // fill and drain; a stalled reader stops new commands
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bufMem[0] <= 9'h000;
      bufMem[1] <= 9'h000;
      wrPtr     <= 1'b0;
      rdPtr     <= 1'b0;
      bufCount  <= 2'h0;
    end
    else
    begin
      if (pushRsp)
      begin
        bufMem[wrPtr] <= {nackSeen, nackSeen ? 8'h00 : rxShift};
        wrPtr         <= ~wrPtr;
      end
      if (rspValid && rspReady)
        rdPtr <= ~rdPtr;
      bufCount <= bufCount + {1'b0, pushRsp}
                - {1'b0, rspValid && rspReady};
    end
  end

  // ============================================================
  // sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state    <= lmu_i2c_pkg::HOST_IDLE;
      qCnt     <= 13'h0000;
      phase    <= 2'h0;
      step     <= 3'h0;
      bitIdx   <= 4'h0;
      isRead   <= 1'b0;
      regIdx   <= 8'h00;
      wrData   <= 8'h00;
      rxShift  <= 8'h00;
      nackSeen <= 1'b0;
    end
    else if (state == lmu_i2c_pkg::HOST_IDLE)
    begin
      if (cmdValid && cmdReady)
      begin
        state    <= lmu_i2c_pkg::HOST_RUN;
        isRead   <= cmdRead;
        regIdx   <= cmdIndex;
        wrData   <= cmdData;
        nackSeen <= 1'b0;
        qCnt     <= 13'h0000;
        phase    <= 2'h0;
        step     <= 3'h0;
        bitIdx   <= 4'h0;
      end
    end
    else
    begin
      qCnt <= qTick ? 13'h0000 : qCnt + 13'h0001;
      if (qTick)
      begin
        phase <= phase + 2'h1;
        // sample at the end of the high half of the clock
        if (phase == 2'h2 && kind == lmu_i2c_pkg::SYM_BYTE_RX
            && bitIdx < 4'h8)
          rxShift <= {rxShift[6:0], sdaSync[1]};
        if (phase == 2'h3)
        begin
          if (kind == lmu_i2c_pkg::SYM_STOP)
            state <= lmu_i2c_pkg::HOST_IDLE;
          else if (kind != lmu_i2c_pkg::SYM_START && bitIdx < 4'h8)
            bitIdx <= bitIdx + 4'h1;
          else
          begin
            bitIdx <= 4'h0;
            // refused byte: skip straight to the stop
            if (nackSeen)
              step <= isRead ? 3'h6 : 3'h4;
            else
              step <= step + 3'h1;
          end
        end
        if (phase == 2'h2 && kind == lmu_i2c_pkg::SYM_BYTE_TX
            && bitIdx == 4'h8 && sdaSync[1])
          nackSeen <= 1'b1;
      end
    end
  end

endmodule : lmu_i2c_host

`default_nettype wire

// File: lmu_i2c_notes_unused.sv
`default_nettype none
`default_nettype wire

// File: lmu_i2c_link_props.sv
// lmu_i2c_link_props.sv: protocol checker for the two-wire register link.
// assumes it sits beside the link interface, sampling on the link clock.
`include "lmu_i2c_map.svh"
`default_nettype none

module lmu_i2c_link_props (
  input wire logic linkClk,   // device oversampling clock
  input wire logic rst_n,     // sync reset, active low
  input wire logic devSdaOut, // device data level
  input wire logic devSdaOe,  // device drives data
  input wire logic scl,       // resolved clock line
  input wire logic sda        // resolved data line
);
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!rst_n);

  // ============================================================
  // frame tracking
  logic       sclQ;      // clock line one sample ago
  logic       sdaQ;      // data line one sample ago
  logic [3:0] bitCnt;    // clock rises in current byte
  logic [7:0] shiftIn;   // bits seen, msb first
  logic       firstByte; // address byte in flight
  logic       inFrame;   // between start and stop
  logic       addressed; // our address was seen
  logic       dirRead;   // frame asks for a read
  wire startSeen = scl & sclQ & sdaQ & ~sda;  // fall with clock high
  wire stopSeen  = scl & sclQ & ~sdaQ & sda;  // rise with clock high
  wire sclRise   = scl & ~sclQ;               // clock edge seen
  wire addrHit   = (shiftIn[7:1] == `SLAVE_ADDR);
  wire ackSlot   = sclRise & (bitCnt == 4'd8); // ninth rise
  wire ackExp    = firstByte ? addrHit : (addressed & ~dirRead);

  // line history, no reset needed
  always_ff @(posedge linkClk)
  begin
    sclQ <= scl;
    sdaQ <= sda;
  end

  // bit counter restarts on every start, repeated too, and on stop
  always_ff @(posedge linkClk)
  begin
    if (!rst_n || startSeen || stopSeen)
      bitCnt <= 4'h0;
    else if (sclRise)
      bitCnt <= (bitCnt == 4'd9) ? 4'd1 : bitCnt + 4'd1;
  end

  // shift data bits, skipping the acknowledge slot
  always_ff @(posedge linkClk)
  begin
    if (sclRise && bitCnt != 4'd8)
      shiftIn <= {shiftIn[6:0], sda};
  end

  // first byte flag and bus busy flag
  always_ff @(posedge linkClk)
  begin
    if (!rst_n || startSeen)
      firstByte <= 1'b1;
    else if (sclRise && bitCnt == 4'd9)
      firstByte <= 1'b0;
  end
  always_ff @(posedge linkClk)
  begin
    if (!rst_n || stopSeen)
      inFrame <= 1'b0;
    else if (startSeen)
      inFrame <= 1'b1;
  end

  // address decision taken at the address acknowledge
  always_ff @(posedge linkClk)
  begin
    if (!rst_n || startSeen)
    begin
      addressed <= 1'b0;
      dirRead   <= 1'b0;
    end
    else if (ackSlot && firstByte)
    begin
      addressed <= addrHit;
      dirRead   <= shiftIn[0];
    end
  end

  // ============================================================
  // assertions
  dev_edge_low_a :
    assert property ($changed(devSdaOe) |-> !scl && !sclQ)
    else $error("device data moved while clock high");
  ack_ninth_a :
    assert property (ackSlot && ackExp |-> !sda && devSdaOe)
    else $error("device missed its acknowledge");
  master_slot_free_a :
    assert property (ackSlot && !firstByte && dirRead |-> !devSdaOe)
    else $error("device held data in master acknowledge");
  idle_release_a :
    assert property (!inFrame |-> !devSdaOe)
    else $error("device drove data outside a frame");
  pull_low_only_a :
    assert property (devSdaOe |-> !devSdaOut
                     && (dirRead || bitCnt >= 4'h8))
    else $error("device drove data high or outside its slot");
  // a frame mark falls under the first clock high after an ack or stop
  frame_edge_only_a :
    assert property (scl && sclQ && (sda != sdaQ)
                     |-> bitCnt == 4'h1)
    else $error("data moved with clock high mid byte");
  ack_prompt_a :
    assert property ($fell(scl) && bitCnt == 4'd8 && ackExp
                     |-> ##[1:8] devSdaOe)
    else $error("acknowledge not driven in time");
  ack_release_a :
    assert property ($fell(scl) && bitCnt == 4'd9 && !dirRead
                     |-> ##[1:8] !devSdaOe)
    else $error("acknowledge not released in time");
endmodule : lmu_i2c_link_props

`default_nettype wire

// File: i2c_register_port_with_gpio_tb_top.sv
// i2c_register_port_with_gpio_tb_top.sv: host and device joined by the link.
// assumes the design files and map header are compiled first.
`include "lmu_i2c_map.svh"
`default_nettype none

module i2c_register_port_with_gpio_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ============================================================
  // signals
  logic       core_clk, linkClk, rst_n;      // clocks and reset
  logic       cmdValid, cmdRead, cmdReady;   // command port
  logic [7:0] cmdIndex, cmdData, rspData;    // command and answer
  logic       rspValid, rspReady, rspError;  // answer port
  logic [2:0] gpioIn, gpioOut, gpioOe;       // pins
  logic [2:0] extPins;                       // far drivers of pins
  logic       pwmEnable, pwmInput;           // pin 0 override
  logic [7:0] ctl, dat;                      // values written
  logic [2:0] oe, pinExp;                    // expected pin state
  int         fails, nChecks;                // tallies
  logic [7:0] corner [5] = '{8'h17, 8'hff, 8'h10, 8'h07, 8'h00};

  // two-way pins: the enabled end wins
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & extPins);

  lmu_i2c_link_if link();
  lmu_i2c_host #(.SCL_PERIOD_NS(200)) lmu_i2c_host_inst (
    .core_clk(core_clk), .rst_n(rst_n), .link(link),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
    .cmdIndex(cmdIndex), .cmdData(cmdData), .rspValid(rspValid),
    .rspReady(rspReady), .rspData(rspData), .rspError(rspError));
  lmu_i2c_device lmu_i2c_device_inst (
    .linkClk(linkClk), .rst_n(rst_n), .link(link), .gpioIn(gpioIn),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .pwmEnable(pwmEnable),
    .pwmInput(pwmInput));
  lmu_i2c_link_props lmu_i2c_link_props_inst (
    .linkClk(linkClk), .rst_n(rst_n), .devSdaOut(link.devSdaOut),
    .devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

  // ============================================================
  // clocks: link clock free running, phase unrelated
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end

  // ============================================================
  // helpers
  function automatic logic [2:0] expOe(input logic [7:0] c);
    return {c[2], c[1], c[0] & ~c[`CTRL_PWM_BIT]};
  endfunction : expOe

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  // offer one command, hold it until taken
  task automatic issue(input logic rd, input logic [7:0] idx,
                       input logic [7:0] val);
    @(posedge core_clk);
    cmdValid <= 1'b1;
    cmdRead  <= rd;
    cmdIndex <= idx;
    cmdData  <= val;
    do @(negedge core_clk); while (cmdReady !== 1'b1);
    @(posedge core_clk);
    cmdValid <= 1'b0;
  endtask : issue

  // write, then wait for the engine to fall idle
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    issue(1'b0, idx, val);
    do @(negedge core_clk); while (cmdReady !== 1'b1);
  endtask : wr

  // take one held answer and compare it
  task automatic pop(input logic [7:0] exp);
    do @(negedge core_clk); while (rspValid !== 1'b1);
    chkByte(rspData, exp);
    chkByte({7'h0, rspError}, 8'h00);
    @(posedge core_clk);
    rspReady <= 1'b1;
    @(posedge core_clk);
    rspReady <= 1'b0;
  endtask : pop

  task automatic wrapUp;
    if (fails == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrapUp

  // ============================================================
  // watchdog: nearly twice the expected run
  initial
  begin
    repeat (80000) @(posedge core_clk);
    fails++;
    wrapUp();
  end

  // ============================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdIndex = 8'h00;
    cmdData = 8'h00;
    rspReady = 1'b0;
    extPins = 3'h0;
    fails = 0;
    nChecks = 0;
    void'($urandom(32'h50da));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    issue(1'b1, `REG_IO_CTRL, 8'h00);
    pop(`CTRL_RESET);
    issue(1'b1, `REG_IO_DATA, 8'h00);
    pop(8'h00);
    // corners first, then random settings
    for (int i = 0; i < 10; i++)
    begin
      ctl = (i < 5) ? corner[i] : 8'($urandom);
      dat = 8'($urandom);
      @(posedge core_clk);
      extPins <= 3'($urandom);
      wr(`REG_IO_CTRL, ctl);
      wr(`REG_IO_DATA, dat);
      repeat (8) @(posedge core_clk);
      oe = expOe(ctl);
      pinExp = (oe & dat[2:0]) | (~oe & extPins);
      chkByte({5'h0, gpioOe}, {5'h0, oe});
      chkByte({5'h0, gpioOut}, {5'h0, dat[2:0]});
      chkByte({7'h0, pwmEnable}, {7'h0, ctl[4]});
      chkByte({7'h0, pwmInput}, {7'h0, pinExp[0]});
      issue(1'b1, `REG_IO_CTRL, 8'h00);
      pop(ctl & `CTRL_WMASK);
      issue(1'b1, `REG_IO_DATA, 8'h00);
      pop({5'h0, pinExp});
    end
    // unmapped index, then two answers held while new commands are refused
    wr(8'h05, 8'h5a);
    issue(1'b1, 8'h05, 8'h00);
    issue(1'b1, `REG_IO_CTRL, 8'h00);
    repeat (1200) @(posedge core_clk);
    @(negedge core_clk);
    chkByte({7'h0, cmdReady}, 8'h00);
    pop(8'h00);
    pop(ctl & `CTRL_WMASK);
    wrapUp();
  end
endmodule : i2c_register_port_with_gpio_tb_top

`default_nettype wire
